//--- rtl/ccdpc_top.sv
// digital side of a 12-bit ccd scanner front end: channel sequencing,
// dc restore, per-pixel and global correction, output formatting.
// assumes sample pulse, coefficients and converter data arrive
// synchronous to clk_i, which is the master clock.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
module ccdpc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // scanner controller side
    input  wire logic        sample_sync_pulse_i,
    input  wire logic        odd_pixel_i,
    input  wire logic        output_enable_n_i,
    input  wire logic [11:0] pixel_offset_coef_i,
    input  wire logic [11:0] pixel_shading_coef_i,
    // converter side
    input  wire logic [11:0] adc_data_i,
    input  wire logic [11:0] adc_reset_level_i,
    output logic      [1:0]  mux_select_o,
    output logic             sample_hold_o,
    output logic             cds_mode_o,
    output logic      [8:0]  dac_code_red_o,
    output logic      [8:0]  dac_code_green_o,
    output logic      [8:0]  dac_code_blue_o,
    // output pins, with enables
    output logic      [15:0] pixel_output_bus_o,
    output logic      [15:0] pixel_output_bus_oe_o,
    output logic      [1:0]  channel_code_out_o,
    output logic             over_range_flag_o,
    output logic             threshold_detect_out_o,
    output logic             flag_oe_o
);
    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    logic [6:0]  ctrl_q;
    logic [11:0] def_even_q;
    logic [11:0] def_odd_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [2:0]  status_q;

    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire bus_wr  = bus_req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];

    function automatic logic [2:0] grp_hit(input logic [7:0] a,
                                           input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        grp_hit = '0;
        if (a >= base && d < 8'h0c && d[1:0] == 2'h0)
            grp_hit = 3'h1 << d[3:2];
    endfunction : grp_hit

    wire [2:0] hit_dac  = grp_hit(wb_adr_i, ccdpc_pkg::ADDR_DAC_BASE);
    wire [2:0] hit_gain = grp_hit(wb_adr_i, ccdpc_pkg::ADDR_GAIN_BASE);
    wire [2:0] hit_gofs = grp_hit(wb_adr_i, ccdpc_pkg::ADDR_GOFS_BASE);
    wire [2:0] hit_thr  = grp_hit(wb_adr_i, ccdpc_pkg::ADDR_THR_BASE);
    wire [1:0] grp_idx  = hit_dac[2] | hit_gain[2] | hit_gofs[2] |
                          hit_thr[2] ? 2'h2 :
                          hit_dac[1] | hit_gain[1] | hit_gofs[1] |
                          hit_thr[1] ? 2'h1 : 2'h0;

    wire is_ctrl = wb_adr_i == ccdpc_pkg::ADDR_CTRL;
    wire is_stat = wb_adr_i == ccdpc_pkg::ADDR_STATUS;
    wire is_even = wb_adr_i == ccdpc_pkg::ADDR_DEF_EVEN;
    wire is_odd  = wb_adr_i == ccdpc_pkg::ADDR_DEF_ODD;

    // per-channel settings kept in small register files
    logic [8:0]  dac_w  [3];
    logic [11:0] gain_w [3];
    logic [11:0] gofs_w [3];
    logic [11:0] thr_w  [3];
    logic [8:0]  dac_rd;
    logic [11:0] gain_rd;
    logic [11:0] gofs_rd;
    logic [11:0] thr_rd;

    ccdpc_coef_mem #(.WIDTH(9), .DEPTH(3),
                     .INIT(ccdpc_pkg::DAC_RESET)) u_dac (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (bus_wr && |hit_dac),
        .waddr_i (grp_idx),
        .wdata_i (wb_dat_i[8:0]),
        .raddr_i (grp_idx),
        .rdata_o (dac_rd),
        .word_o  (dac_w)
    );
    ccdpc_coef_mem #(.WIDTH(12), .DEPTH(3),
                     .INIT(ccdpc_pkg::GAIN_RESET)) u_gain (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (bus_wr && |hit_gain),
        .waddr_i (grp_idx),
        .wdata_i (wb_dat_i[11:0]),
        .raddr_i (grp_idx),
        .rdata_o (gain_rd),
        .word_o  (gain_w)
    );
    ccdpc_coef_mem #(.WIDTH(12), .DEPTH(3),
                     .INIT(ccdpc_pkg::GOFS_RESET)) u_gofs (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (bus_wr && |hit_gofs),
        .waddr_i (grp_idx),
        .wdata_i (wb_dat_i[11:0]),
        .raddr_i (grp_idx),
        .rdata_o (gofs_rd),
        .word_o  (gofs_w)
    );
    ccdpc_coef_mem #(.WIDTH(12), .DEPTH(3),
                     .INIT(ccdpc_pkg::THR_RESET)) u_thr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (bus_wr && |hit_thr),
        .waddr_i (grp_idx),
        .wdata_i (wb_dat_i[11:0]),
        .raddr_i (grp_idx),
        .rdata_o (thr_rd),
        .word_o  (thr_w)
    );

    // read data of the memories comes one cycle late, so a read of them is
    // answered on the second edge; writes are answered on the first
    logic rd_wait_q;
    wire  any_grp = |{hit_dac, hit_gain, hit_gofs, hit_thr};
    wire  rd_go   = bus_req && !wb_we_i && (!any_grp || rd_wait_q);

    wire [31:0] rd_mux =
        is_ctrl ? {25'h0, ctrl_q} :
        is_stat ? {29'h0, status_q} :
        is_even ? {20'h0, def_even_q} :
        is_odd  ? {20'h0, def_odd_q} :
        |hit_dac  ? {23'h0, dac_rd} :
        |hit_gain ? {20'h0, gain_rd} :
        |hit_gofs ? {20'h0, gofs_rd} :
        |hit_thr  ? {20'h0, thr_rd} : ccdpc_pkg::BUS_UNMAPPED;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q     <= ccdpc_pkg::CTRL_RESET;
            def_even_q <= ccdpc_pkg::DEF_RESET;
            def_odd_q  <= ccdpc_pkg::DEF_RESET;
            ack_q      <= 1'b0;
            rdat_q     <= '0;
            rd_wait_q  <= 1'b0;
        end
        else
        begin
            ack_q     <= (bus_req && wb_we_i) || rd_go;
            rd_wait_q <= bus_req && !wb_we_i && any_grp && !rd_wait_q;
            if (rd_go)
                rdat_q <= rd_mux;
            if (bus_wr && is_ctrl)
                ctrl_q <= wb_dat_i[6:0];
            if (bus_wr && is_even)
                def_even_q <= wb_dat_i[11:0];
            if (bus_wr && is_odd)
                def_odd_q <= wb_dat_i[11:0];
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    wire       mono    = ctrl_q[ccdpc_pkg::CTRL_MONO_BIT];
    wire       use_def = ctrl_q[ccdpc_pkg::CTRL_DEFR_BIT];
    wire [1:0] wlen    = ctrl_q[ccdpc_pkg::CTRL_LEN_LSB +: 2];
    wire [1:0] mono_ch = ctrl_q[ccdpc_pkg::CTRL_MCH_LSB +: 2];

    assign cds_mode_o       = ctrl_q[ccdpc_pkg::CTRL_CDS_BIT];
    assign dac_code_red_o   = dac_w[0];
    assign dac_code_green_o = dac_w[1];
    assign dac_code_blue_o  = dac_w[2];

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_RED   = 4'b0010,
        ST_GREEN = 4'b0100,
        ST_BLUE  = 4'b1000
    } ccdpc_state_e;

    ccdpc_state_e st_q;
    ccdpc_state_e st_d;
    logic [2:0]   div_q;

    // one conversion per two master clocks
    wire tick = div_q == ccdpc_pkg::MCLK_DIV - 3'h1;
    // word taken on the edge ending a slot, while the mux still
    // selects that channel; a late strobe pairs it with the next one
    wire conv_colour = st_q != ST_IDLE && tick;
    // mono converts on every pulse, whatever the divider phase
    wire conv_mono   = mono && st_q == ST_IDLE && sample_sync_pulse_i;
    wire conv        = conv_colour || conv_mono;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:  if (sample_sync_pulse_i)
                          st_d = mono ? ST_IDLE : ST_RED;
            ST_RED:   if (tick) st_d = ST_GREEN;
            ST_GREEN: if (tick) st_d = ST_BLUE;
            // a pulse on the second clock of the last slot starts the next pixel at once,
            // so pulses six clocks apart lose nothing
            ST_BLUE:
                if (tick)
                    st_d = sample_sync_pulse_i ? ST_RED : ST_IDLE;
            default:  st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q   <= ST_IDLE;
            div_q  <= '0;
        end
        else
        begin
            st_q   <= st_d;
            div_q  <= (sample_sync_pulse_i || tick) ? 3'h0 : div_q + 3'h1;
        end
    end

    assign mux_select_o  = mono ? mono_ch :
                           st_q == ST_GREEN ? ccdpc_pkg::CODE_GREEN :
                           st_q == ST_BLUE  ? ccdpc_pkg::CODE_BLUE :
                           ccdpc_pkg::CODE_RED;
    assign sample_hold_o = sample_sync_pulse_i;

    // ------------------------------------------------------------------
    // correction datapath
    // ------------------------------------------------------------------
    logic [1:0] ch_q;
    wire  [1:0] ch = mux_select_o;
    // a mono channel of 3 is folded onto red for the settings
    wire  [1:0] chi = (ch == 2'h3) ? 2'h0 : ch;

    // dc restore: remove reset level (cds) or mid-scale (dac ref)
    wire signed [13:0] restored = cds_mode_o ?
        $signed({2'b00, adc_data_i}) - $signed({2'b00, adc_reset_level_i}) :
        $signed({2'b00, adc_data_i}) - 14'sh0800;
    wire [11:0] pofs = (use_def ? (odd_pixel_i ? def_odd_q : def_even_q)
                                : pixel_offset_coef_i);
    wire signed [14:0] ofs_corr = 15'(restored) -
                                  $signed({3'b000, pofs});
    // shading gain is unsigned 2.10, global gain likewise
    wire signed [28:0] shade = 29'(ofs_corr) *
                               $signed({17'h0, pixel_shading_coef_i});
    wire signed [18:0] shaded = 19'(shade >>> ccdpc_pkg::GAIN_FRAC);
    wire signed [32:0] glob = 33'(shaded) * $signed({21'h0, gain_w[chi]});
    wire signed [22:0] gained = 23'(glob >>> ccdpc_pkg::GAIN_FRAC);
    wire signed [22:0] pix = gained + 23'($signed(gofs_w[chi]));

    // ------------------------------------------------------------------
    // output formatting
    // ------------------------------------------------------------------
    wire        neg    = pix < 0;
    wire [21:0] mag    = neg ? 22'h0 : pix[21:0];
    wire [21:0] lim    = wlen == ccdpc_pkg::LEN_8  ? 22'h0000ff :
                         wlen == ccdpc_pkg::LEN_10 ? 22'h0003ff :
                         wlen == ccdpc_pkg::LEN_12 ? 22'h000fff :
                         22'h00ffff;
    wire        over   = mag > lim;
    wire [15:0] clip   = over ? lim[15:0] : mag[15:0];
    wire [15:0] word   = wlen == ccdpc_pkg::LEN_16 ? clip :
                         {neg, clip[14:0]};
    wire        thr_hit = !neg && mag > {10'h0, thr_w[chi]};

    // code and flags load with the word, never apart
    logic [15:0] out_q;
    logic        over_range_flag_q;
    logic        det_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_q    <= '0;
            ch_q     <= ccdpc_pkg::CODE_RED;
            over_range_flag_q   <= 1'b0;
            det_q    <= 1'b0;
            status_q <= '0;
        end
        else if (conv)
        begin
            out_q    <= word;
            ch_q     <= chi;
            over_range_flag_q   <= over && wlen != ccdpc_pkg::LEN_16;
            det_q    <= thr_hit;
            status_q <= {thr_hit, over, neg};
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    // enables follow the pin directly; data is not gated, so the bus keeps the last word
    assign flag_oe_o              = !output_enable_n_i;
    assign pixel_output_bus_oe_o  = {16{flag_oe_o}};
    assign pixel_output_bus_o     = out_q;
    assign channel_code_out_o     = ch_q;
    assign over_range_flag_o      = over_range_flag_q;
    assign threshold_detect_out_o = det_q;
endmodule : ccdpc_top

//--- rtl/ccdpc_pkg.sv
// package for the ccd scanner pixel correction block
// assumes one 25 MHz clock and classic wishbone register access
package ccdpc_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_DAC_BASE  = 8'h08;
    localparam logic [7:0] ADDR_GAIN_BASE = 8'h14;
    localparam logic [7:0] ADDR_GOFS_BASE = 8'h20;
    localparam logic [7:0] ADDR_THR_BASE  = 8'h2c;
    localparam logic [7:0] ADDR_DEF_EVEN  = 8'h38;
    localparam logic [7:0] ADDR_DEF_ODD   = 8'h3c;
    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    localparam int CTRL_MONO_BIT = 0;
    localparam int CTRL_CDS_BIT  = 1;
    localparam int CTRL_LEN_LSB  = 2;
    localparam int CTRL_DEFR_BIT = 4;
    localparam int CTRL_MCH_LSB  = 5;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [8:0]  DAC_RESET  = 9'h000;
    localparam logic [11:0] GAIN_RESET = 12'h400;
    localparam int          GAIN_FRAC  = 10;
    localparam logic [11:0] GOFS_RESET = 12'h000;
    localparam logic [11:0] THR_RESET  = 12'hfff;
    localparam logic [11:0] DEF_RESET  = 12'h000;
    localparam logic [1:0]  CODE_RED   = 2'h0;
    localparam logic [1:0]  CODE_GREEN = 2'h1;
    localparam logic [1:0]  CODE_BLUE  = 2'h2;
    localparam logic [1:0]  LEN_8      = 2'h0;
    localparam logic [1:0]  LEN_10     = 2'h1;
    localparam logic [1:0]  LEN_12     = 2'h2;
    localparam logic [1:0]  LEN_16     = 2'h3;
    localparam logic [2:0]  MCLK_DIV   = 3'h2;
    localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;
endpackage : ccdpc_pkg

//--- rtl/ccdpc_coef_mem.sv
// small register file holding the per-channel settings
// assumes a single writer port and a registered read port
module ccdpc_coef_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 3,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             we_i,
    input  wire logic [1:0]       waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [1:0]       raddr_i,
    output logic      [WIDTH-1:0] rdata_o,
    output logic      [WIDTH-1:0] word_o [DEPTH]
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++)
    begin : g_word
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                mem_q[g] <= INIT;
            else if (we_i && waddr_i == 2'(g))
                mem_q[g] <= wdata_i;
        end
        assign word_o[g] = mem_q[g];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_o <= INIT;
        else if (raddr_i < 2'(DEPTH))
            rdata_o <= mem_q[raddr_i];
        else
            rdata_o <= '0;
    end
endmodule : ccdpc_coef_mem

//--- dv/ccdpc_ctrl_model.sv
// scanner controller model: sample pulse and converter words
// assumes the bench requests pulses and supplies per-channel samples
module ccdpc_ctrl_model
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fire_i,
    input  wire logic [1:0]  mux_select_i,
    input  wire logic [35:0] adc_vals_i,
    output logic             sample_sync_pulse_o,
    output logic      [11:0] adc_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] gap_q;
    // ------------------------------------------------------------------
    // pulse spacing and converter data
    // ------------------------------------------------------------------
    // a request inside the guard is dropped, not queued: six clocks
    // between pulses is legal in colour and in mono alike
    assign sample_sync_pulse_o = fire_i && gap_q == 3'h0;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            gap_q <= 3'h0;
        else if (sample_sync_pulse_o)
            gap_q <= 3'h5;
        else if (gap_q != 3'h0)
            gap_q <= gap_q - 3'h1;
    end
    // word follows the selected channel; an unused code gives a
    // changing pattern so that a stale value is never mistaken
    assign adc_data_o = (mux_select_i == 2'h3) ? {6'h2a, gap_q, 3'h5}
                      : adc_vals_i[12 * mux_select_i +: 12];
endmodule : ccdpc_ctrl_model

//--- dv/ccdpc_top_asserts.sv
// checker for the pixel correction block, bound to its top module
// assumes one clock and a synchronous active high reset
module ccdpc_top_asserts
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic        sample_sync_pulse_i,
    input wire logic        output_enable_n_i,
    input wire logic [1:0]  mux_select_o,
    input wire logic        sample_hold_o,
    input wire logic        cds_mode_o,
    input wire logic [8:0]  dac_code_red_o,
    input wire logic [8:0]  dac_code_green_o,
    input wire logic [8:0]  dac_code_blue_o,
    input wire logic [15:0] pixel_output_bus_o,
    input wire logic [15:0] pixel_output_bus_oe_o,
    input wire logic [1:0]  channel_code_out_o,
    input wire logic        over_range_flag_o,
    input wire logic        threshold_detect_out_o,
    input wire logic        flag_oe_o
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    bus_enable_a: assert property (
        pixel_output_bus_oe_o == {16{!output_enable_n_i}})
        else $error("pixel bus enable does not follow enable input");
    flag_enable_a: assert property (
        flag_oe_o == !output_enable_n_i)
        else $error("flag enable does not follow enable input");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    ack_time_a: assert property (
        $rose(wb_cyc_i && wb_stb_i) |-> ##[1:2] wb_ack_o)
        else $error("bus ack late");
    reset_clear_a: assert property ($fell(rst_i) |->
        !wb_ack_o && pixel_output_bus_o == 16'h0000 && !over_range_flag_o
        && channel_code_out_o == 2'h0 && !threshold_detect_out_o)
        else $error("outputs not cleared by reset");
    cfg_write_a: assert property (
        $changed({dac_code_red_o, dac_code_green_o, dac_code_blue_o,
                  cds_mode_o}) |-> wb_ack_o && wb_we_i)
        else $error("setting changed without a bus write");
    code_legal_a: assert property (channel_code_out_o != 2'h3)
        else $error("channel code out of range");
    mux_legal_a: assert property (mux_select_o != 2'h3)
        else $error("mux select out of range");
    hold_follow_a: assert property (
        sample_sync_pulse_i |-> ##[0:1] sample_hold_o)
        else $error("sample hold missing after pulse");
    word_flags_a: assert property (
        $changed({channel_code_out_o, over_range_flag_o,
                  threshold_detect_out_o}) |->
        $past(sample_sync_pulse_i, 1) || $past(sample_sync_pulse_i, 3) ||
        $past(sample_sync_pulse_i, 5) || $past(sample_sync_pulse_i, 7))
        else $error("code or flags changed outside a word");
    cover property (wb_ack_o && !wb_we_i);
    cover property (threshold_detect_out_o);
    cover property (over_range_flag_o);
endmodule : ccdpc_top_asserts

bind ccdpc_top ccdpc_top_asserts u_asserts (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_ack_o, .sample_sync_pulse_i,
    .output_enable_n_i, .mux_select_o, .sample_hold_o, .cds_mode_o,
    .dac_code_red_o, .dac_code_green_o, .dac_code_blue_o,
    .pixel_output_bus_o, .pixel_output_bus_oe_o, .channel_code_out_o,
    .over_range_flag_o, .threshold_detect_out_o, .flag_oe_o);

//--- dv/ccd_scanner_pixel_correction_tb_top.sv
// self-checking bench: register access, colour and mono pixel runs
// assumes the controller model and the bound checker are compiled
module ccd_scanner_pixel_correction_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_req = 1'b0, wb_we = 1'b0;
    logic        fire = 1'b0, odd = 1'b0, oe_n = 1'b0;
    logic        wb_ack, sync, cds_pin, over, thr, mono, correlated_double_sampling;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rdat;
    logic [11:0] lvl = 12'h800, ofs = 12'h000, shd = 12'h400, adc;
    logic [35:0] vals = 36'h0;
    logic [26:0] dacs;
    logic [15:0] bus;
    logic [1:0]  mux, code, len, mch;
    logic [2:0]  expf [3];
    logic [15:0] expw [3];
    logic [8:0]  d9;
    int          num_errors = 0, check_count = 0, cycles = 0;
    int          v [3], g [3], t [3], o, s, base;
    logic [7:0]  r_adr [8] = '{8'h00, 8'h04, 8'h0c, 8'h14, 8'h28, 8'h30,
                               8'h3c, 8'hfc};
    logic [31:0] r_val [8] = '{32'h0, 32'h0, 32'h0, 32'h400, 32'h0,
                               32'hfff, 32'h0, 32'h0};
    ccdpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req),
        .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .sample_sync_pulse_i(sync), .odd_pixel_i(odd),
        .output_enable_n_i(oe_n), .pixel_offset_coef_i(ofs),
        .pixel_shading_coef_i(shd), .adc_data_i(adc),
        .adc_reset_level_i(lvl), .mux_select_o(mux), .sample_hold_o(),
        .cds_mode_o(cds_pin), .dac_code_red_o(dacs[8:0]),
        .dac_code_green_o(dacs[17:9]), .dac_code_blue_o(dacs[26:18]),
        .pixel_output_bus_o(bus), .pixel_output_bus_oe_o(),
        .channel_code_out_o(code), .over_range_flag_o(over),
        .threshold_detect_out_o(thr), .flag_oe_o());
    ccdpc_ctrl_model partner (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .mux_select_i(mux), .adc_vals_i(vals),
        .sample_sync_pulse_o(sync), .adc_data_o(adc));
    // ------------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // the request holds until ack is seen; the timeout cuts a hang
    task automatic wb_xfer(input logic we, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] sel);
        @(posedge clk_i);
        wb_req  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_sel  <= sel;
        wb_wdat <= d;
        do
            @(posedge clk_i);
        while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_req <= 1'b0;
    endtask : wb_xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 32'h0, 4'hf);
        check(rdat, e);
    endtask : rd_chk
    function automatic logic [2:0] exp_flags(input int p, input int lim,
                                             input logic [1:0] l);
        int w;
        w = (l == 2'h3) ? 16 : 8 + 2 * l;
        return {p > lim, w < 16 && p > (1 << w) - 1, w < 16 && p < 0};
    endfunction : exp_flags
    function automatic logic [15:0] exp_word(input int p,
                                             input logic [1:0] l);
        int m;
        m = (l == 2'h3) ? 16'hffff : (256 << (2 * l)) - 1;
        if (p < 0)
            return (l == 2'h3) ? 16'h0 : 16'h8000;
        return 16'((p > m) ? m : p);
    endfunction : exp_word
    task automatic run_pixel(input logic m, input logic [1:0] mc);
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        for (int i = 0; i < (m ? 1 : 3); i++)
        begin
            int ch;
            ch = m ? int'(mc) : i;
            repeat ((i == 0 && !m) ? 3 : 2) @(posedge clk_i);
            #1;
            check(32'(code), 32'(ch));
            check(32'({thr, over}), 32'(expf[ch][2:1]));
            check(32'(bus[15]), 32'(expf[ch][0]));
            check(32'(bus), 32'(expw[ch]));
        end
    endtask : run_pixel
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h10a572b8));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd_chk(r_adr[i], r_val[i]);
        for (int c = 0; c < 3; c++)
        begin
            d9 = 9'($urandom);
            wr(8'(ccdpc_pkg::ADDR_DAC_BASE + 4 * c), 32'(d9));
            wb_xfer(1'b1, 8'(ccdpc_pkg::ADDR_DAC_BASE + 4 * c),
                    32'(~d9), 4'h0);
            rd_chk(8'(ccdpc_pkg::ADDR_DAC_BASE + 4 * c), 32'(d9));
            check(32'(dacs[9 * c +: 9]), 32'(d9));
        end
        wr(ccdpc_pkg::ADDR_CTRL, 32'h18);
        wr(ccdpc_pkg::ADDR_DEF_EVEN, 32'h100);
        for (int c = 0; c < 3; c++)
            wr(8'(ccdpc_pkg::ADDR_THR_BASE + 4 * c), 32'h100);
        vals <= {3{12'h980}};
        for (int k = 0; k < 2; k++)
        begin
            odd <= k[0];
            expf = '{default: 3'(4 * k)};
            // restored 0x180 less the even default 0x100 or odd 0
            expw = '{default: 16'(128 + 256 * k)};
            run_pixel(1'b0, 2'h0);
        end
        for (int n = 0; n < 24; n++)
        begin
            mono = 1'($urandom_range(0, 1));
            correlated_double_sampling  = 1'($urandom_range(0, 1));
            len  = 2'($urandom_range(0, 3));
            mch  = 2'($urandom_range(0, 2));
            o    = $urandom_range(0, 63);
            s    = $urandom_range(1, 2);
            base = $urandom_range(1536, 2560);
            wr(ccdpc_pkg::ADDR_CTRL, {25'h0, mch, 1'b0, len, correlated_double_sampling, mono});
            lvl  <= 12'(base);
            base = correlated_double_sampling ? base : 2048;
            ofs  <= 12'(o);
            shd  <= 12'(s * 1024);
            oe_n <= 1'($urandom_range(0, 1));
            odd  <= 1'($urandom_range(0, 1));
            for (int c = 0; c < 3; c++)
            begin
                v[c] = int'($urandom_range(0, 448)) - 224;
                g[c] = $urandom_range(1, 2);
                t[c] = $urandom_range(0, 1023);
                vals[12 * c +: 12] <= 12'(base + v[c] + o);
                wr(8'(ccdpc_pkg::ADDR_GAIN_BASE + 4 * c), 32'(g[c] * 1024));
                wr(8'(ccdpc_pkg::ADDR_THR_BASE + 4 * c), 32'(t[c]));
                expf[c] = exp_flags(v[c] * s * g[c], t[c], len);
                expw[c] = exp_word(v[c] * s * g[c], len);
            end
            check(32'(cds_pin), 32'(correlated_double_sampling));
            run_pixel(mono, mch);
        end
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(ccdpc_pkg::ADDR_GAIN_BASE, 32'h400);
        check(32'(dacs), 32'h0);
        print_verdict();
    end
endmodule : ccd_scanner_pixel_correction_tb_top
